// file: sfl_flash_seq.sv
// Serial flash lock read, page write and page program sequencer
`timescale 1ns/1ps
// What this block does
// - Lock read takes opcode then three address bytes, bits latched on rising clock.
// - After the address the sector lock value shifts out on falling clock edges.
// - Chip select high during output stops driving and ends the read.
// - Lock read during a busy cycle is rejected, cycle undisturbed.
// - Lock-down bit freezes both lock bits until reset or power-up.
// - Write lock bit set blocks page write and page program in that sector.
// - Page write and program need the write-enable latch set first.
// - Page write replaces the sent bytes; unsent bytes keep old values.
// - Data past the page end wraps to offset zero of that page.
// - Over 256 data bytes, only the last 256 are stored.
// - Under 256 bytes, only addressed bytes change.
// - Select rising off a byte boundary cancels write or program.
// - Valid page write starts timed cycle; busy flag high until done.
// - Valid page program starts timed cycle; busy flag pollable.
// - Write-enable latch clears before the timed cycle completes.
// - Writes to a protected page are not executed.
// - Write or program during a busy cycle is rejected.
// - Reset pin low aborts the cycle and enters reset mode.
// - Page program only clears bits, never sets them.
// - Top three address bits are ignored.
module sfl_flash_seq import sfl_pkg::*; #(
  parameter int PAGE_AW = 4,
  parameter int REWRITE_CYCLES = REWRITE_CYC,
  parameter int PROGRAM_CYCLES = PROGRAM_CYC
) (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic reset_n_i,
  output logic sdo_o,
  output logic sdo_drive_n_o,
  // Protection and lock register load
  input wire logic area_protect_i,
  input wire logic lock_wr_i,
  input wire logic [SECT_W-1:0] lock_sect_i,
  input wire logic [1:0] lock_data_i,
  // Status
  output logic write_in_progress_flag_o,
  output logic write_enable_latch_o,
  // Memory read-back
  input wire logic [PAGE_AW+7:0] mem_rd_addr_i,
  output logic [7:0] mem_rd_data_o
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [SECT_W-1:0] sect_of(input logic [23:0] a);
    return a[SECT_LSB+SECT_W-1:SECT_LSB];
  endfunction

  function automatic logic [PAGE_AW-1:0] page_of(input logic [23:0] a);
    return a[PAGE_LSB+PAGE_AW-1:PAGE_LSB];
  endfunction

  logic sck_m, sck_s, sck_p, cs_m, cs_s, cs_p, di_m, di_s, rp_m, rp_s;
  sfl_frame_type fr_q;
  sfl_flash_type fl_q;
  logic [7:0] op_q, sh_q, idx_q, out_q, cidx_q, rd_q;
  logic [2:0] bit_q;
  logic [1:0] abyte_q;
  logic [23:0] addr_q;
  logic got_q, sdo_q, drv_n_q, wr_latch_q, prog_q;
  logic [PAGE_BYTES-1:0] vld_q;
  logic [7:0] pbuf [PAGE_BYTES];
  logic [7:0] mem [PAGE_BYTES << PAGE_AW];
  logic [1:0] lock_q [NUM_SECT];
  logic [TMR_W-1:0] tmr_q;
  logic [PAGE_AW-1:0] pg_q;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_p <= 1'b1;
      di_m <= 1'b0;
      di_s <= 1'b0;
      rp_m <= 1'b1;
      rp_s <= 1'b1;
    end else if (ce_i) begin
      sck_m <= sclk_i;
      sck_s <= sck_m;
      sck_p <= sck_s;
      cs_m <= cs_n_i;
      cs_s <= cs_m;
      cs_p <= cs_s;
      di_m <= sdi_i;
      di_s <= di_m;
      rp_m <= reset_n_i;
      rp_s <= rp_m;
    end
  end

  wire rmode = ~rp_s;
  wire rise = sck_s & ~sck_p & ~cs_s;
  wire fall = ~sck_s & sck_p & ~cs_s;
  wire cs_end = cs_s & ~cs_p;
  wire [7:0] byte_in = {sh_q[6:0], di_s};
  wire byte_done = rise & (bit_q == BIT_LAST);
  wire addr_last = byte_done & (fr_q == FR_ADDR) & (abyte_q == ADDR_LAST);
  wire [23:0] addr_in = {addr_q[15:0], byte_in};
  wire is_wr = (op_q == OP_PAGE_REWRITE) | (op_q == OP_PAGE_PROGRAM);
  wire wr_ok = (fr_q == FR_DATA) & got_q & (bit_q == 3'h0) & is_wr;
  wire prot = area_protect_i | lock_q[sect_of(addr_q)][LK_WLOCK];
  wire go = cs_end & ~rmode & wr_ok & wr_latch_q & (fl_q == FL_IDLE) & ~prot;
  wire wen_go = cs_end & (fr_q == FR_WEN) & (bit_q == 3'h0);

  // ****************************************
  // Instruction frame decode
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fr_q <= FR_CMD;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      abyte_q <= 2'h0;
      addr_q <= 24'h000000;
      idx_q <= 8'h00;
      got_q <= 1'b0;
    end else if (ce_i) begin
      if (cs_s | rmode) begin
        fr_q <= FR_CMD;
        bit_q <= 3'h0;
        abyte_q <= 2'h0;
        got_q <= 1'b0;
      end else if (rise) begin
        bit_q <= bit_q + 3'h1;
        sh_q <= byte_in;
        if (byte_done) begin
          case (fr_q)
            FR_CMD: begin
              op_q <= byte_in;
              if (byte_in == OP_WR_ENABLE) begin
                fr_q <= FR_WEN;
              end else if (fl_q == FL_IDLE && (byte_in == OP_LOCK_READ || byte_in == OP_PAGE_REWRITE ||
                                               byte_in == OP_PAGE_PROGRAM)) begin
                fr_q <= FR_ADDR;
              end else begin
                fr_q <= FR_SKIP;
              end
            end
            FR_ADDR: begin
              addr_q <= addr_in;
              abyte_q <= abyte_q + 2'h1;
              if (abyte_q == ADDR_LAST) begin
                fr_q <= (op_q == OP_LOCK_READ) ? FR_OUT : FR_DATA;
                idx_q <= byte_in;
              end
            end
            FR_DATA: begin
              idx_q <= idx_q + 8'h01;
              got_q <= 1'b1;
            end
            FR_WEN: fr_q <= FR_SKIP;
            default: ;
          endcase
        end
      end
    end
  end

  // ****************************************
  // Page buffer
  // ****************************************
  always_ff @(posedge core_clk_i) begin
    if (ce_i && byte_done && fr_q == FR_DATA) begin
      pbuf[idx_q] <= byte_in;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vld_q <= '0;
    end else if (ce_i) begin
      if (addr_last) begin
        vld_q <= '0;
      end else if (byte_done && fr_q == FR_DATA) begin
        vld_q[idx_q] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Lock register output
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= 8'h00;
      sdo_q <= 1'b0;
      drv_n_q <= 1'b1;
    end else if (ce_i) begin
      if (cs_s | rmode) begin
        drv_n_q <= 1'b1;
      end else if (addr_last && op_q == OP_LOCK_READ) begin
        out_q <= {LK_RSVD, lock_q[sect_of(addr_in)]};
      end else if (fr_q == FR_OUT && fall) begin
        sdo_q <= out_q[7];
        out_q <= {out_q[6:0], out_q[7]};
        drv_n_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Sector lock registers
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SECT; i++) begin
        lock_q[i] <= LK_RESET;
      end
    end else if (ce_i) begin
      if (rmode) begin
        for (int i = 0; i < NUM_SECT; i++) begin
          lock_q[i] <= LK_RESET;
        end
      end else if (lock_wr_i && !lock_q[lock_sect_i][LK_LDOWN]) begin
        lock_q[lock_sect_i] <= lock_data_i;
      end
    end
  end

  // ****************************************
  // Self-timed cycle
  // ****************************************
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fl_q <= FL_IDLE;
      tmr_q <= '0;
      wr_latch_q <= 1'b0;
      pg_q <= '0;
      prog_q <= 1'b0;
      cidx_q <= 8'h00;
    end else if (ce_i) begin
      if (rmode) begin
        fl_q <= FL_IDLE;
        wr_latch_q <= 1'b0;
      end else begin
        case (fl_q)
          FL_IDLE: begin
            if (wen_go) begin
              wr_latch_q <= 1'b1;
            end
            if (go) begin
              fl_q <= FL_BUSY;
              tmr_q <= (op_q == OP_PAGE_PROGRAM) ? TMR_W'(PROGRAM_CYCLES) : TMR_W'(REWRITE_CYCLES);
              pg_q <= page_of(addr_q);
              prog_q <= (op_q == OP_PAGE_PROGRAM);
              wr_latch_q <= 1'b0;
            end
          end
          FL_BUSY: begin
            if (tmr_q <= TMR_W'(1)) begin
              fl_q <= FL_COMMIT;
              cidx_q <= 8'h00;
            end else begin
              tmr_q <= tmr_q - TMR_W'(1);
            end
          end
          FL_COMMIT: begin
            cidx_q <= cidx_q + 8'h01;
            if (cidx_q == IDX_LAST) begin
              fl_q <= FL_IDLE;
            end
          end
          default: fl_q <= FL_IDLE;
        endcase
      end
    end
  end

  // Page write replaces sent bytes after an implied erase; program only clears bits
  wire [7:0] cm_old = mem[{pg_q, cidx_q}];
  wire [7:0] cm_wdat = prog_q ? (cm_old & pbuf[cidx_q]) : pbuf[cidx_q];

  always_ff @(posedge core_clk_i) begin
    if (ce_i && !rmode && fl_q == FL_COMMIT && vld_q[cidx_q]) begin
      mem[{pg_q, cidx_q}] <= cm_wdat;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_q <= 8'h00;
    end else if (ce_i) begin
      rd_q <= mem[mem_rd_addr_i];
    end
  end

  assign sdo_o = sdo_q;
  assign sdo_drive_n_o = drv_n_q;
  // Busy and commit states share bit 0, so the flag is a flop
  assign write_in_progress_flag_o = fl_q[0];
  assign write_enable_latch_o = wr_latch_q;
  assign mem_rd_data_o = rd_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cmd_busy;
    ce_i && byte_done && fr_q == FR_CMD && fl_q != FL_IDLE;
  endsequence
  sequence s_start;
    ce_i && go;
  endsequence

  a_read_reject: assert property (s_cmd_busy ##0 byte_in == OP_LOCK_READ |=> fr_q == FR_SKIP)
    else $error("lock read accepted while busy");
  a_write_reject: assert property (s_cmd_busy ##0 (byte_in == OP_PAGE_REWRITE || byte_in == OP_PAGE_PROGRAM)
                                   |=> fr_q == FR_SKIP)
    else $error("write accepted while busy");
  a_out_release: assert property (ce_i && cs_end |=> sdo_drive_n_o)
    else $error("output still driven after deselect");
  a_start_busy: assert property (s_start |=> write_in_progress_flag_o && !write_enable_latch_o ##1 fl_q == FL_BUSY)
    else $error("timed cycle did not start");
  a_need_latch: assert property (ce_i && cs_end && fl_q == FL_IDLE && !wr_latch_q |=> fl_q == FL_IDLE)
    else $error("write started without latch");
  a_partial_drop: assert property (ce_i && cs_end && fl_q == FL_IDLE && bit_q != 3'h0 |=> fl_q == FL_IDLE)
    else $error("write started off byte boundary");
  a_lock_block: assert property (ce_i && cs_end && fl_q == FL_IDLE && prot |=> fl_q == FL_IDLE)
    else $error("write started in locked sector");
  a_wrap_idx: assert property (ce_i && byte_done && fr_q == FR_DATA && idx_q == IDX_LAST |=> idx_q == 8'h00)
    else $error("buffer index did not wrap");
  a_prog_clear: assert property (ce_i && fl_q == FL_COMMIT && prog_q |-> (cm_wdat & ~cm_old) == 8'h00)
    else $error("program sets a bit");
  a_rst_abort: assert property (ce_i && rmode && fl_q != FL_IDLE |=> !write_in_progress_flag_o && !wr_latch_q)
    else $error("reset did not abort cycle");
  a_ldown_hold: assert property (ce_i && !rmode && lock_q[lock_sect_i][LK_LDOWN] |=> lock_q[$past(lock_sect_i)][LK_LDOWN])
    else $error("lock-down bit cleared");
endmodule

// file: sfl_host.sv
// Host serial master model that drives the flash link pins
`timescale 1ns/1ps
module sfl_host (
  // Clock
  input wire logic core_clk_i,
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // ********
  // Frame driver
  // ********
  logic [7:0] tx_q[$];
  logic [7:0] rx_byte;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic half();
    repeat (6) @(posedge core_clk_i);
  endtask
  // One 125 ns link clock: low phase with new data and output sample, then high
  task automatic bit_step(input logic d);
    sclk_o <= 1'b0;
    sdi_o <= d;
    #55;
    rx_byte = {rx_byte[6:0], sdo_i};
    #7.5;
    sclk_o <= 1'b1;
    #62.5;
  endtask
  // Whole queue in one select period; cut drops the last bits of the final byte
  task automatic frame(input int cut, input int n_rd);
    logic [7:0] b;
    @(posedge core_clk_i);
    cs_n_o <= 1'b0;
    half();
    while (tx_q.size() > 0) begin
      b = tx_q.pop_front();
      for (int i = 7; i >= 0; i--) begin
        if (tx_q.size() > 0 || i >= cut) bit_step(b[i]);
      end
    end
    repeat (8 * n_rd) bit_step(~sdi_o);
    sclk_o <= 1'b0;
    half();
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    half();
  endtask
endmodule

// file: sfl_pkg.sv
// Constants and types for the serial flash instruction sequencer
package sfl_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  // Plain defaults; the real cycle lengths are set per instance
  localparam int REWRITE_TIME_US = 1000;
  localparam int PROGRAM_TIME_US = 100;
  localparam int REWRITE_CYC = REWRITE_TIME_US * CLK_MHZ;
  localparam int PROGRAM_CYC = PROGRAM_TIME_US * CLK_MHZ;
  localparam int TMR_W = 21;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_WR_ENABLE = 8'h16;
  localparam logic [7:0] OP_LOCK_READ = 8'h2a;
  localparam logic [7:0] OP_PAGE_REWRITE = 8'h3c;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h4d;
  // ****************************************
  // Address and lock register layout
  // ****************************************
  localparam int SECT_LSB = 16;
  localparam int SECT_W = 5;
  localparam int NUM_SECT = 32;
  localparam int PAGE_LSB = 8;
  localparam int PAGE_BYTES = 256;
  localparam int LK_WLOCK = 0;
  localparam int LK_LDOWN = 1;
  localparam logic [1:0] LK_RESET = 2'h0;
  localparam logic [5:0] LK_RSVD = 6'h00;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] IDX_LAST = 8'hff;

  typedef enum logic [2:0] {
    FR_CMD = 3'b000,
    FR_ADDR = 3'b001,
    FR_DATA = 3'b010,
    FR_OUT = 3'b011,
    FR_SKIP = 3'b100,
    FR_WEN = 3'b101
  } sfl_frame_type;

  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_BUSY = 2'b01,
    FL_COMMIT = 2'b11
  } sfl_flash_type;
endpackage

// file: tb_top.sv
// Self-checking bench for the serial flash sequencer
`timescale 1ns/1ps
module tb_top import sfl_pkg::*; ;
  // ********
  // Signals and instances
  // ********
  localparam int CYC = 3000;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, sdi, sdo, sdo_drive_n, busy, latch;
  logic reset_n = 1'b1;
  logic area_protect = 1'b0;
  logic lock_wr = 1'b0;
  logic [4:0] lock_sect = 5'h00;
  logic [1:0] lock_data = 2'h0;
  logic drv_seen = 1'b0;
  logic drv_clr = 1'b0;
  logic [11:0] mem_addr = 12'h000;
  logic [7:0] mem_data;
  logic [7:0] pg [256];
  int err_total = 0;
  int n_compared = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) drv_seen <= drv_clr ? 1'b0 : (drv_seen | !sdo_drive_n);
  sfl_host host (.core_clk_i(core_clk), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
  sfl_flash_seq #(.PAGE_AW(4), .REWRITE_CYCLES(CYC), .PROGRAM_CYCLES(CYC)) dut (
    .core_clk_i(core_clk), .rst_i(rst), .ce_i(1'b1), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .reset_n_i(reset_n), .sdo_o(sdo), .sdo_drive_n_o(sdo_drive_n), .area_protect_i(area_protect),
    .lock_wr_i(lock_wr), .lock_sect_i(lock_sect), .lock_data_i(lock_data),
    .write_in_progress_flag_o(busy), .write_enable_latch_o(latch), .mem_rd_addr_i(mem_addr),
    .mem_rd_data_o(mem_data));
  // ********
  // Shared tasks
  // ********
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic wait_busy(input logic lvl, input int bound);
    int n;
    n = 0;
    while (busy !== lvl) begin
      @(posedge core_clk);
      n++;
      if (n > bound) begin
        chk(busy, lvl);
        stop_test();
      end
    end
  endtask
  task automatic load_lock(input logic [4:0] s, input logic [1:0] d);
    @(posedge core_clk);
    lock_sect <= s;
    lock_data <= d;
    lock_wr <= 1'b1;
    @(posedge core_clk);
    lock_wr <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    host.tx_q.push_back(op);
    host.tx_q.push_back(a[23:16]);
    host.tx_q.push_back(a[15:8]);
    host.tx_q.push_back(a[7:0]);
  endtask
  task automatic wr_enable();
    host.tx_q.push_back(OP_WR_ENABLE);
    host.frame(0, 0);
  endtask
  task automatic rd_lock(input logic [23:0] a, input logic [7:0] exp);
    cmd(OP_LOCK_READ, a);
    host.frame(0, 2);
    chk(host.rx_byte, exp);
    chk(sdo_drive_n, 1'b1);
  endtask
  task automatic one_byte(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d, input int cut);
    cmd(op, a);
    host.tx_q.push_back(d);
    host.frame(cut, 0);
  endtask
  task automatic chk_page();
    for (int i = 0; i < 256; i++) begin
      @(posedge core_clk);
      mem_addr <= {4'h1, 8'(i)};
      repeat (2) @(posedge core_clk);
      chk(mem_data, pg[i]);
    end
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_lock();
    load_lock(5'h05, 2'h1);
    load_lock(5'h03, 2'h2);
    load_lock(5'h03, 2'h1);
    rd_lock(24'he53412, 8'h01);
    rd_lock(24'h03ffff, 8'h02);
    $display("test lock read done");
  endtask
  task automatic t_full();
    wr_enable();
    chk(latch, 1'b1);
    cmd(OP_PAGE_REWRITE, 24'he00100);
    for (int k = 0; k < 258; k++) begin
      host.tx_q.push_back(8'(k >> 1) ^ 8'h5a);
      pg[k % 256] = 8'(k >> 1) ^ 8'h5a;
    end
    host.frame(0, 0);
    wait_busy(1'b1, 20);
    chk(latch, 1'b0);
    wait_busy(1'b0, CYC + 400);
    chk_page();
    $display("test full page done");
  endtask
  task automatic t_wrap();
    wr_enable();
    cmd(OP_PAGE_REWRITE, 24'h0001fe);
    for (int k = 0; k < 4; k++) begin
      host.tx_q.push_back(8'ha0 + 8'(k));
      pg[(254 + k) % 256] = 8'ha0 + 8'(k);
    end
    host.frame(0, 0);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, CYC + 400);
    chk_page();
    $display("test wrap done");
  endtask
  task automatic t_prog();
    wr_enable();
    cmd(OP_PAGE_PROGRAM, 24'h000110);
    host.tx_q.push_back(8'h0f);
    host.tx_q.push_back(8'hf0);
    pg[16] = pg[16] & 8'h0f;
    pg[17] = pg[17] & 8'hf0;
    host.frame(0, 0);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, CYC + 400);
    chk_page();
    $display("test program done");
  endtask
  task automatic t_refuse();
    for (int c = 0; c < 4; c++) begin
      if (c > 0) wr_enable();
      if (c == 2) load_lock(5'h00, 2'h1);
      @(posedge core_clk);
      area_protect <= (c == 3);
      one_byte(c[0] ? OP_PAGE_PROGRAM : OP_PAGE_REWRITE, 24'h000140, 8'h00, c == 1 ? 3 : 0);
      repeat (40) @(posedge core_clk);
      chk(busy, 1'b0);
    end
    area_protect <= 1'b0;
    load_lock(5'h00, 2'h0);
    chk_page();
    $display("test refusals done");
  endtask
  task automatic t_busy();
    wr_enable();
    one_byte(OP_PAGE_REWRITE, 24'h000120, 8'h77, 0);
    pg[32] = 8'h77;
    wait_busy(1'b1, 20);
    drv_clr <= 1'b1;
    @(posedge core_clk);
    drv_clr <= 1'b0;
    cmd(OP_LOCK_READ, 24'h050000);
    host.frame(0, 1);
    chk(drv_seen, 1'b0);
    one_byte(OP_PAGE_PROGRAM, 24'h000120, 8'h00, 0);
    chk(busy, 1'b1);
    wait_busy(1'b0, CYC + 400);
    chk_page();
    $display("test busy refusal done");
  endtask
  task automatic t_rstpin();
    wr_enable();
    one_byte(OP_PAGE_PROGRAM, 24'h000130, 8'h00, 0);
    wait_busy(1'b1, 20);
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(busy, 1'b0);
    chk(latch, 1'b0);
    reset_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    rd_lock(24'he53412, 8'h00);
    $display("test reset pin done");
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk(busy, 1'b0);
    t_lock();
    t_full();
    t_wrap();
    t_prog();
    t_refuse();
    t_busy();
    t_rstpin();
    stop_test();
  end
endmodule
